// ---- bcb_match.sv ----
/*
  Channel B break matcher: compare data, data mask, cycle qualifier,
  address and address mask registers, condition logic and sticky flags.
  Assumes register accesses and bus cycles arrive from the core end on the
  shared clock, one register access per cycle at most.
*/
// Summary of operation
// (R1) 32-bit compare data, read/write, reset zero
// (R2) software gives nonzero size with data compare
// (R3) byte size: duplicate compare byte both lanes
// (R4) data mask: one bit excludes bit
// (R5) byte size: duplicate mask byte both lanes
// (R6) qualifier bits 15:8 read zero
// (R7) bus select: off, local, internal, local
// (R8) cycle type: none, fetch, data, either
// (R9) direction: none, read, write, either
// (R10) size: any, byte, word, longword
// (R11) address mask one bit removes address bit
// (R12) sticky match flags, cleared by writing zero
// (R13) all enabled comparisons agree same cycle
`timescale 1ns/1ps
module bcb_match #(
  parameter int DATA_W = bcb_pkg::DATA_W
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  bcb_if.device bus
);
  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (DATA_W != 32) begin : g_bad_width
    $error("bcb_match supports only a 32-bit data path");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic masked_eq(input logic [31:0] a, input logic [31:0] b,
                                     input logic [31:0] m);
    masked_eq = ((a ^ b) & ~m) == 32'h0000_0000;
  endfunction

  // true when a two-bit selector admits the cycle; off means not compared
  function automatic logic sel_ok(input logic [1:0] sel, input logic is_two);
    case (sel)
      bcb_pkg::SEL_OFF: sel_ok = 1'b1;
      bcb_pkg::SEL_ONE: sel_ok = !is_two;
      bcb_pkg::SEL_TWO: sel_ok = is_two;
      default: sel_ok = 1'b1;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0] cmp_data_r, cmp_data_nxt;
  logic [31:0] data_mask_r, data_mask_nxt;
  logic [7:0] qual_r, qual_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] addr_mask_r, addr_mask_nxt;
  logic data_en_r, data_en_nxt;
  logic loc_flag_r, loc_flag_nxt;
  logic int_flag_r, int_flag_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic match_r, match_nxt;

  logic [1:0] bus_sel, type_sel, dir_sel, size_sel;
  logic bus_hit, type_hit, dir_hit, size_hit, addr_hit, data_hit;
  logic cond_met;
  logic [31:0] lane_data, lane_cmp, lane_mask;

  assign bus_sel = qual_r[bcb_pkg::QUAL_BUS_LSB +: 2];
  assign type_sel = qual_r[bcb_pkg::QUAL_TYPE_LSB +: 2];
  assign dir_sel = qual_r[bcb_pkg::QUAL_DIR_LSB +: 2];
  assign size_sel = qual_r[bcb_pkg::QUAL_SIZE_LSB +: 2];

  // ---------------------------------------------------------------
  // condition logic
  // ---------------------------------------------------------------
  always_comb begin
    // both select codes that name the local bus pick local cycles
    case (bus_sel) // R7
      bcb_pkg::SEL_OFF: bus_hit = 1'b0;
      bcb_pkg::SEL_TWO: bus_hit = bus.cyc_internal;
      default: bus_hit = !bus.cyc_internal;
    endcase
    type_hit = sel_ok(type_sel, !bus.cyc_fetch); // R8
    dir_hit = sel_ok(dir_sel, bus.cyc_write); // R9
    case (size_sel) // R10
      bcb_pkg::SIZE_BYTE: size_hit = bus.cyc_size == bcb_pkg::SIZE_BYTE;
      bcb_pkg::SIZE_WORD: size_hit = bus.cyc_size == bcb_pkg::SIZE_WORD;
      bcb_pkg::SIZE_LONG: size_hit = bus.cyc_size == bcb_pkg::SIZE_LONG;
      default: size_hit = 1'b1;
    endcase
    addr_hit = masked_eq(bus.cyc_addr, addr_r, addr_mask_r); // R11
    // byte data rides lane 15:8 at even addresses, 7:0 at odd; the
    // duplicated compare byte lets one register serve either lane
    lane_data = bus.cyc_data;
    lane_cmp = cmp_data_r;
    lane_mask = data_mask_r;
    case (size_sel)
      bcb_pkg::SIZE_BYTE: begin // R3 R5
        lane_data = {24'h000000, bus.cyc_addr[0] ? bus.cyc_data[7:0] : bus.cyc_data[15:8]};
        lane_cmp = {24'h000000, bus.cyc_addr[0] ? cmp_data_r[7:0] : cmp_data_r[15:8]};
        lane_mask = {24'hFFFFFF, bus.cyc_addr[0] ? data_mask_r[7:0] : data_mask_r[15:8]};
      end
      bcb_pkg::SIZE_WORD: begin
        lane_mask = {16'hFFFF, data_mask_r[15:0]};
      end
      default: begin
        lane_mask = data_mask_r;
      end
    endcase
    data_hit = !data_en_r || masked_eq(lane_data, lane_cmp, lane_mask); // R1 R4 R2
    cond_met = bus.cyc_valid && bus_hit && type_hit && dir_hit && size_hit
               && addr_hit && data_hit; // R13
  end

  // ---------------------------------------------------------------
  // register file and flags
  // ---------------------------------------------------------------
  always_comb begin
    cmp_data_nxt = cmp_data_r;
    data_mask_nxt = data_mask_r;
    qual_nxt = qual_r;
    addr_nxt = addr_r;
    addr_mask_nxt = addr_mask_r;
    data_en_nxt = data_en_r;
    loc_flag_nxt = loc_flag_r;
    int_flag_nxt = int_flag_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    match_nxt = cond_met;
    if (bus.reg_wr) begin
      case (bus.reg_idx)
        bcb_pkg::IDX_COMPARE_DATA: cmp_data_nxt = bus.reg_wdata; // R1
        bcb_pkg::IDX_DATA_MASK: data_mask_nxt = bus.reg_wdata; // R4
        bcb_pkg::IDX_CYCLE_QUAL: qual_nxt = bus.reg_wdata[7:0]; // R6
        bcb_pkg::IDX_ADDRESS: addr_nxt = bus.reg_wdata;
        bcb_pkg::IDX_ADDRESS_MASK: addr_mask_nxt = bus.reg_wdata;
        bcb_pkg::IDX_CONTROL: begin
          data_en_nxt = bus.reg_wdata[bcb_pkg::CTL_DATA_EN_BIT];
          // writing one leaves a flag alone, only zero clears
          if (!bus.reg_wdata[bcb_pkg::CTL_LOC_FLAG_BIT]) begin // R12
            loc_flag_nxt = 1'b0;
          end
          if (!bus.reg_wdata[bcb_pkg::CTL_INT_FLAG_BIT]) begin // R12
            int_flag_nxt = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // set after clear so a same-cycle match is never lost
    if (cond_met && !bus.cyc_internal) begin // R12
      loc_flag_nxt = 1'b1;
    end
    if (cond_met && bus.cyc_internal) begin // R12
      int_flag_nxt = 1'b1;
    end
    if (bus.reg_rd) begin
      rvalid_nxt = 1'b1;
      case (bus.reg_idx)
        bcb_pkg::IDX_COMPARE_DATA: rdata_nxt = cmp_data_r;
        bcb_pkg::IDX_DATA_MASK: rdata_nxt = data_mask_r;
        bcb_pkg::IDX_CYCLE_QUAL: rdata_nxt = {24'h000000, qual_r}; // R6
        bcb_pkg::IDX_ADDRESS: rdata_nxt = addr_r;
        bcb_pkg::IDX_ADDRESS_MASK: rdata_nxt = addr_mask_r;
        bcb_pkg::IDX_CONTROL: begin
          rdata_nxt = 32'h0000_0000;
          rdata_nxt[bcb_pkg::CTL_DATA_EN_BIT] = data_en_r;
          rdata_nxt[bcb_pkg::CTL_LOC_FLAG_BIT] = loc_flag_r;
          rdata_nxt[bcb_pkg::CTL_INT_FLAG_BIT] = int_flag_r;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cmp_data_r <= bcb_pkg::RST_WORD;
      data_mask_r <= bcb_pkg::RST_WORD;
      qual_r <= bcb_pkg::RST_QUAL;
      addr_r <= bcb_pkg::RST_WORD;
      addr_mask_r <= bcb_pkg::RST_WORD;
      data_en_r <= 1'b0;
      loc_flag_r <= 1'b0;
      int_flag_r <= 1'b0;
      rdata_r <= bcb_pkg::RST_WORD;
      rvalid_r <= 1'b0;
      match_r <= 1'b0;
    end else begin
      cmp_data_r <= cmp_data_nxt;
      data_mask_r <= data_mask_nxt;
      qual_r <= qual_nxt;
      addr_r <= addr_nxt;
      addr_mask_r <= addr_mask_nxt;
      data_en_r <= data_en_nxt;
      loc_flag_r <= loc_flag_nxt;
      int_flag_r <= int_flag_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      match_r <= match_nxt;
    end
  end

  assign bus.reg_rdata = rdata_r;
  assign bus.reg_rvalid = rvalid_r;
  assign bus.local_flag = loc_flag_r;
  assign bus.internal_flag = int_flag_r;
  assign bus.match_pulse = match_r;
endmodule

// ---- bcb_pkg.sv ----
/*
  Shared constants for the channel B break match block: register indices,
  field positions, reset values and bus cycle encodings.
  Assumes both ends of the bcb_if interface compile against this package.
*/
package bcb_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int IDX_W = 3;
  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [2:0] IDX_COMPARE_DATA = 3'h0;
  localparam logic [2:0] IDX_DATA_MASK = 3'h1;
  localparam logic [2:0] IDX_CYCLE_QUAL = 3'h2;
  localparam logic [2:0] IDX_ADDRESS = 3'h3;
  localparam logic [2:0] IDX_ADDRESS_MASK = 3'h4;
  localparam logic [2:0] IDX_CONTROL = 3'h5;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_QUAL = 8'h00;
  // ---------------------------------------------------------------
  // cycle qualifier fields
  // ---------------------------------------------------------------
  localparam int QUAL_W = 8;
  localparam int QUAL_BUS_LSB = 6;
  localparam int QUAL_TYPE_LSB = 4;
  localparam int QUAL_DIR_LSB = 2;
  localparam int QUAL_SIZE_LSB = 0;
  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTL_DATA_EN_BIT = 0;
  localparam int CTL_INT_FLAG_BIT = 12;
  localparam int CTL_LOC_FLAG_BIT = 14;
  // ---------------------------------------------------------------
  // two-bit field encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_ONE = 2'h1;
  localparam logic [1:0] SEL_TWO = 2'h2;
  localparam logic [1:0] SEL_ANY = 2'h3;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LONG = 2'h3;
endpackage

// ---- bcb_if.sv ----
/*
  Interface joining the break channel B matcher and the processor core side.
  Assumes one shared clock; the testbench instantiates and connects it.
*/
`timescale 1ns/1ps
interface bcb_if (
  input wire logic core_clk_i
);
  logic reg_wr;
  logic reg_rd;
  logic [2:0] reg_idx;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic cyc_valid;
  logic cyc_internal;
  logic cyc_fetch;
  logic cyc_write;
  logic [1:0] cyc_size;
  logic [31:0] cyc_addr;
  logic [31:0] cyc_data;
  logic local_flag;
  logic internal_flag;
  logic match_pulse;

  modport device (
    input reg_wr, reg_rd, reg_idx, reg_wdata,
    input cyc_valid, cyc_internal, cyc_fetch, cyc_write, cyc_size, cyc_addr, cyc_data,
    output reg_rdata, reg_rvalid, local_flag, internal_flag, match_pulse
  );
  modport core (
    output reg_wr, reg_rd, reg_idx, reg_wdata,
    output cyc_valid, cyc_internal, cyc_fetch, cyc_write, cyc_size, cyc_addr, cyc_data,
    input reg_rdata, reg_rvalid, local_flag, internal_flag, match_pulse
  );
endinterface

// ---- bcb_core_end.sv ----
/*
  Core end of the break channel B link: registers the user's register
  accesses and observed bus cycles onto bcb_if and returns read data and
  match status. Assumes the user keeps the software-side setup rules.
*/
`timescale 1ns/1ps
module bcb_core_end (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [2:0] idx_i,
  input wire logic [31:0] wdata_i,
  input wire logic cyc_valid_i,
  input wire logic cyc_internal_i,
  input wire logic cyc_fetch_i,
  input wire logic cyc_write_i,
  input wire logic [1:0] cyc_size_i,
  input wire logic [31:0] cyc_addr_i,
  input wire logic [31:0] cyc_data_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic local_flag_o,
  output logic internal_flag_o,
  output logic match_o,
  bcb_if.core bus
);
  // ---------------------------------------------------------------
  // request side
  // ---------------------------------------------------------------
  logic wr_r, wr_nxt, rd_r, rd_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [37:0] cyc_r, cyc_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [3:0] stat_r, stat_nxt;

  always_comb begin
    wr_nxt = wr_i;
    rd_nxt = rd_i && !wr_i;
    idx_nxt = idx_i;
    // qualifier high byte always written as zero
    wdata_nxt = (idx_i == bcb_pkg::IDX_CYCLE_QUAL) ? {24'h000000, wdata_i[7:0]} : wdata_i; // R6
    cyc_nxt = {cyc_valid_i, cyc_internal_i, cyc_fetch_i, cyc_write_i, cyc_size_i,
               cyc_addr_i};
    rdata_nxt = bus.reg_rvalid ? bus.reg_rdata : rdata_r;
    stat_nxt = {bus.reg_rvalid, bus.local_flag, bus.internal_flag, bus.match_pulse};
  end

  logic [31:0] cdata_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      idx_r <= 3'h0;
      wdata_r <= bcb_pkg::RST_WORD;
      cyc_r <= 38'h0;
      cdata_r <= bcb_pkg::RST_WORD;
      rdata_r <= bcb_pkg::RST_WORD;
      stat_r <= 4'h0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      idx_r <= idx_nxt;
      wdata_r <= wdata_nxt;
      cyc_r <= cyc_nxt;
      cdata_r <= cyc_data_i;
      rdata_r <= rdata_nxt;
      stat_r <= stat_nxt;
    end
  end

  assign bus.reg_wr = wr_r;
  assign bus.reg_rd = rd_r;
  assign bus.reg_idx = idx_r;
  assign bus.reg_wdata = wdata_r;
  assign bus.cyc_valid = cyc_r[37];
  assign bus.cyc_internal = cyc_r[36];
  assign bus.cyc_fetch = cyc_r[35];
  assign bus.cyc_write = cyc_r[34];
  assign bus.cyc_size = cyc_r[33:32];
  assign bus.cyc_addr = cyc_r[31:0];
  assign bus.cyc_data = cdata_r;
  assign rdata_o = rdata_r;
  assign rvalid_o = stat_r[3];
  assign local_flag_o = stat_r[2];
  assign internal_flag_o = stat_r[1];
  assign match_o = stat_r[0];
endmodule

// ---- bcb_assertions.sv ----
/*
  Checker for the channel B break link, watching the bcb_if signals.
  Assumes the testbench instantiates it beside the interface.
*/
`timescale 1ns/1ps
module bcb_assertions (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_idx,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic cyc_valid,
  input wire logic cyc_internal,
  input wire logic cyc_fetch,
  input wire logic cyc_write,
  input wire logic [1:0] cyc_size,
  input wire logic local_flag,
  input wire logic internal_flag,
  input wire logic match_pulse
);
  // ---------------------------------------------------------------
  // shadow of the qualifier, so each match can be traced to its cause
  // ---------------------------------------------------------------
  logic [7:0] qual_r;
  logic [7:0] qual_nxt;
  logic sel_ok_r;
  logic sel_ok_nxt;
  always_comb begin
    qual_nxt = qual_r;
    if (reg_wr && reg_idx == bcb_pkg::IDX_CYCLE_QUAL) begin
      qual_nxt = reg_wdata[7:0];
    end
    sel_ok_nxt = cyc_valid && (qual_r[7:6] == 2'h2 ? cyc_internal :
                 (qual_r[7:6] != 2'h0 && !cyc_internal));
    sel_ok_nxt = sel_ok_nxt && (qual_r[5:4] != 2'h1 || cyc_fetch)
                 && (qual_r[5:4] != 2'h2 || !cyc_fetch);
    sel_ok_nxt = sel_ok_nxt && (qual_r[3:2] != 2'h1 || !cyc_write)
                 && (qual_r[3:2] != 2'h2 || cyc_write);
    sel_ok_nxt = sel_ok_nxt && (qual_r[1:0] == 2'h0 || qual_r[1:0] == cyc_size);
  end
  always_ff @(posedge core_clk_i) begin
    qual_r <= rst_i ? 8'h00 : qual_nxt;
    sel_ok_r <= rst_i ? 1'h0 : sel_ok_nxt;
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_read_answer; reg_rd |=> reg_rvalid; endproperty
  property p_no_stray_answer; !reg_rd |=> !reg_rvalid; endproperty
  property p_qual_reserved;
    reg_rd && reg_idx == bcb_pkg::IDX_CYCLE_QUAL |=> reg_rdata[31:8] == 24'h0;
  endproperty
  property p_bus_off; cyc_valid && qual_r[7:6] == 2'h0 |=> !match_pulse; endproperty
  property p_match_cause; match_pulse |-> sel_ok_r; endproperty
  property p_idle_no_match; !cyc_valid |=> !match_pulse; endproperty
  property p_flag_route;
    match_pulse |-> ($past(cyc_internal) ? internal_flag : local_flag);
  endproperty
  property p_local_sticky;
    local_flag && !(reg_wr && reg_idx == bcb_pkg::IDX_CONTROL && !reg_wdata[14])
      |=> local_flag;
  endproperty
  property p_int_sticky;
    internal_flag && !(reg_wr && reg_idx == bcb_pkg::IDX_CONTROL && !reg_wdata[12])
      |=> internal_flag;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  a_no_stray_answer: assert property (p_no_stray_answer) else $error("stray answer");
  a_qual_reserved: assert property (p_qual_reserved) else $error("reserved bits set");
  a_bus_off: assert property (p_bus_off) else $error("match while off");
  a_match_cause: assert property (p_match_cause) else $error("match without cause");
  a_idle_no_match: assert property (p_idle_no_match) else $error("match on idle");
  a_flag_route: assert property (p_flag_route) else $error("wrong flag");
  a_local_sticky: assert property (p_local_sticky) else $error("local flag lost");
  a_int_sticky: assert property (p_int_sticky) else $error("internal flag lost");
  c_local_match: cover property (match_pulse && !internal_flag);
  c_int_match: cover property (match_pulse && internal_flag);
  c_flag_clear: cover property ($fell(local_flag));
endmodule

// ---- bcb_match_tb.sv ----
/*
  Testbench: both link ends joined by bcb_if, driven from the core end user side.
  Assumes the core end adds one cycle each way and the matcher one cycle.
*/
`timescale 1ns/1ps
module bcb_match_tb;
  logic core_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wr = 1'h0, rd = 1'h0, cv = 1'h0, ci = 1'h0, cf = 1'h0, cw = 1'h0;
  logic [2:0] idx = 3'h0;
  logic [1:0] cs = 2'h1, s = 2'h1;
  logic [31:0] wdata = 32'h0, ca = 32'h0, cd = 32'h0, rdata, r;
  logic rvalid, lflag, iflag, match;
  logic [2:0] vq = 3'h0;
  logic [31:0] rq[$];
  logic mq[$];
  logic [31:0] m_cmp = 32'h0, m_msk = 32'h0, m_addr = 32'h0, m_amsk = 32'h0;
  logic [7:0] m_qual = 8'h00;
  logic m_en = 1'h0, e_loc = 1'h0, e_int = 1'h0;
  int fail_count = 0, total_checks = 0, cycles = 0, seed = 6;
  always #12.5 core_clk_i = ~core_clk_i;
  bcb_if bus_if (.core_clk_i(core_clk_i));
  bcb_match u_bcb_match (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus(bus_if.device));
  bcb_core_end u_bcb_core_end (.core_clk_i(core_clk_i), .rst_i(rst_i), .wr_i(wr), .rd_i(rd),
    .idx_i(idx), .wdata_i(wdata), .cyc_valid_i(cv), .cyc_internal_i(ci), .cyc_fetch_i(cf),
    .cyc_write_i(cw), .cyc_size_i(cs), .cyc_addr_i(ca), .cyc_data_i(cd), .rdata_o(rdata),
    .rvalid_o(rvalid), .local_flag_o(lflag), .internal_flag_o(iflag), .match_o(match),
    .bus(bus_if.core));
  bcb_assertions u_bcb_assertions (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_wr(bus_if.reg_wr), .reg_rd(bus_if.reg_rd), .reg_idx(bus_if.reg_idx),
    .reg_wdata(bus_if.reg_wdata), .reg_rdata(bus_if.reg_rdata),
    .reg_rvalid(bus_if.reg_rvalid), .cyc_valid(bus_if.cyc_valid),
    .cyc_internal(bus_if.cyc_internal), .cyc_fetch(bus_if.cyc_fetch),
    .cyc_write(bus_if.cyc_write), .cyc_size(bus_if.cyc_size),
    .local_flag(bus_if.local_flag), .internal_flag(bus_if.internal_flag),
    .match_pulse(bus_if.match_pulse));
  // ---------------------------------------------------------------
  // reference model and drivers
  // ---------------------------------------------------------------
  function automatic logic exp_match(input logic i, input logic f, input logic w,
                                     input logic [1:0] z, input logic [31:0] a, d);
    logic ok;
    logic [31:0] lane;
    ok = (m_qual[7:6] == 2'h2) ? i : (m_qual[7:6] != 2'h0 && !i);
    ok = ok && (m_qual[5:4] != 2'h1 || f) && (m_qual[5:4] != 2'h2 || !f);
    ok = ok && (m_qual[3:2] != 2'h1 || !w) && (m_qual[3:2] != 2'h2 || w);
    ok = ok && (m_qual[1:0] == 2'h0 || m_qual[1:0] == z);
    ok = ok && (((a ^ m_addr) & ~m_amsk) == 32'h0);
    lane = (m_qual[1:0] == bcb_pkg::SIZE_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    if (m_qual[1:0] == bcb_pkg::SIZE_BYTE) begin
      lane = a[0] ? 32'h0000_00FF : 32'h0000_FF00;
    end
    return ok && (!m_en || ((d ^ m_cmp) & ~m_msk & lane) == 32'h0);
  endfunction
  function automatic logic [31:0] ctl_exp();
    return {17'h0, e_loc, 1'h0, e_int, 11'h0, m_en};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [2:0] i, input logic [31:0] v);
    @(posedge core_clk_i);
    cv <= 1'h0;
    wr <= 1'h1;
    idx <= i;
    wdata <= v;
    case (i)
      3'h0: m_cmp = v;
      3'h1: m_msk = v;
      3'h2: m_qual = v[7:0];
      3'h3: m_addr = v;
      3'h4: m_amsk = v;
      3'h5: begin
        m_en = v[0];
        e_loc = e_loc & v[14];
        e_int = e_int & v[12];
      end
      default: ;
    endcase
    @(posedge core_clk_i);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [2:0] i, input logic [31:0] exp);
    @(posedge core_clk_i);
    cv <= 1'h0;
    rd <= 1'h1;
    idx <= i;
    rq.push_back(exp);
    @(posedge core_clk_i);
    rd <= 1'h0;
  endtask
  // cycles stay back to back until the next register access
  task automatic bus_cyc(input logic i, input logic f, input logic w,
                         input logic [1:0] z, input logic [31:0] a, d);
    logic m;
    m = exp_match(i, f, w, z, a, d);
    @(posedge core_clk_i);
    cv <= 1'h1;
    ci <= i;
    cf <= f;
    cw <= w;
    cs <= z;
    ca <= a;
    cd <= d;
    mq.push_back(m);
    e_int = e_int | (m & i);
    e_loc = e_loc | (m & !i);
  endtask
  // ---------------------------------------------------------------
  // result watcher and hang guard
  // ---------------------------------------------------------------
  always @(posedge core_clk_i) begin
    vq <= {vq[1:0], cv && !rst_i};
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      fail_count++;
      end_of_test();
    end
  end
  always @(negedge core_clk_i) begin
    if (rvalid === 1'h1) begin
      if (rq.size() == 0) check(32'h1, 32'h0);
      else check(rdata, rq.pop_front());
    end
    if (vq[2] && mq.size() != 0) begin
      check({31'h0, match}, {31'h0, mq.pop_front()});
    end
  end
  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 8; i++) rd_reg(i[2:0], 32'h0);
    for (int i = 0; i < 5; i++) begin
      r = $random(seed);
      wr_reg(i[2:0], r);
      rd_reg(i[2:0], (i == 2) ? {24'h0, r[7:0]} : r);
    end
    wr_reg(3'h6, 32'hFFFF_FFFF);
    rd_reg(3'h6, 32'h0);
    // every qualifier code, address ignored, data compare off
    wr_reg(3'h4, 32'hFFFF_FFFF);
    wr_reg(3'h5, 32'h0000_5000);
    for (int q = 0; q < 256; q++) begin
      wr_reg(3'h2, q);
      repeat (4) begin
        r = $random(seed);
        bus_cyc(r[0], r[1], r[2], (r[4:3] == 2'h0) ? 2'h2 : r[4:3], r, ~r);
      end
    end
    rd_reg(3'h5, ctl_exp());
    wr_reg(3'h5, 32'h0);
    rd_reg(3'h5, 32'h0);
    @(negedge core_clk_i);
    check({31'h0, lflag}, 32'h0);
    check({31'h0, iflag}, 32'h0);
    // masked address and data with lane duplication for bytes
    for (int k = 0; k < 60; k++) begin
      r = $random(seed);
      s = (r[1:0] == 2'h0) ? 2'h3 : r[1:0];
      wr_reg(3'h0, (s == bcb_pkg::SIZE_BYTE) ? {r[31:16], r[15:8], r[15:8]} : r);
      r = $random(seed) & $random(seed);
      wr_reg(3'h1, (s == bcb_pkg::SIZE_BYTE) ? {r[31:16], r[7:0], r[7:0]} : r);
      wr_reg(3'h3, $random(seed));
      wr_reg(3'h4, $random(seed) & $random(seed) & $random(seed));
      wr_reg(3'h2, {24'h0, (r[17:16] == 2'h0) ? 2'h2 : r[17:16], 4'hF, s});
      wr_reg(3'h5, 32'h0000_5001);
      repeat (6) begin
        r = $random(seed);
        bus_cyc(r[0], r[1], r[2], r[3] ? s : (r[5:4] | 2'h1),
                m_addr ^ (r[6] ? ($random(seed) & m_amsk) : (32'h1 << r[12:8])),
                m_cmp ^ (r[7] ? 32'h0 : (32'h1 << r[20:16])));
      end
    end
    rd_reg(3'h5, ctl_exp());
    repeat (6) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check({31'h0, lflag}, {31'h0, e_loc});
    check({31'h0, iflag}, {31'h0, e_int});
    end_of_test();
  end
endmodule
